// ---- rtl/brp_defs.svh ----
`ifndef BRP_DEFS_SVH
`define BRP_DEFS_SVH
// Timing figures in milliseconds and the clock rate in kHz
`define BRP_CLK_KHZ 40000
`define BRP_SETTLE_MS 30
`define BRP_STROBE_MS 40
`define BRP_RELEASE_MS 16
`define BRP_PERIOD_MS 64
// Derived cycle counts
`define BRP_SETTLE_CYC (`BRP_SETTLE_MS * `BRP_CLK_KHZ)
`define BRP_STROBE_CYC (`BRP_STROBE_MS * `BRP_CLK_KHZ)
`define BRP_RELEASE_CYC (`BRP_RELEASE_MS * `BRP_CLK_KHZ)
`define BRP_PERIOD_CYC (`BRP_PERIOD_MS * `BRP_CLK_KHZ)
`define BRP_CNT_W 32
`define BRP_FIFO_DEPTH 16
`endif

// ---- rtl/brp_pkg.sv ----
package brp_pkg;
	typedef enum logic [3:0]
	{
		BRP_IDLE = 4'h1,
		BRP_SETTLE = 4'h2,
		BRP_STROBE = 4'h4,
		BRP_TAIL = 4'h8
	} brp_state_e;
	typedef logic [31:0] brp_cnt_t;
endpackage

// ---- rtl/brp_fifo.sv ----
`timescale 1ns/100ps
module brp_fifo #(
	parameter int WIDTH = 20,
	parameter int DEPTH = 16
)
(
	input wire logic clk_in, // Clock
	input wire logic rst_n_in, // Synchronised reset
	input wire logic [WIDTH-1:0] wr_data_in, // Write data
	input wire logic wr_valid_in, // Write request
	output logic wr_ready_out, // Not full
	output logic [WIDTH-1:0] rd_data_out, // Registered read data
	output logic rd_valid_out, // Not empty
	input wire logic rd_ready_in // Pop
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed
	{
		logic [AW:0] wp;
		logic [AW:0] rp;
		logic [WIDTH-1:0] rdat;
	} brp_fifo_s;
	brp_fifo_s q;
	brp_fifo_s d;
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic full;
	logic empty;
	logic push;
	logic pop;

	// Pointer compare with wrap bit
	assign empty = (q.wp == q.rp);
	assign full = (q.wp[AW] != q.rp[AW]) && (q.wp[AW-1:0] == q.rp[AW-1:0]);
	assign push = wr_valid_in && !full;
	assign pop = rd_ready_in && !empty;
	assign wr_ready_out = !full;
	assign rd_valid_out = !empty;
	assign rd_data_out = q.rdat;

	// Next pointers; head word registered on pop
	always_comb
	begin
		d = q;
		if (push)
			d.wp = q.wp + 1'b1;
		if (pop)
		begin
			d.rp = q.rp + 1'b1;
			d.rdat = mem_q[q.rp[AW-1:0]];
		end
	end

	// Storage
	always_ff @(posedge clk_in)
	begin
		if (push)
			mem_q[q.wp[AW-1:0]] <= wr_data_in;
	end

	// State register
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			q <= '0;
		else
			q <= d;
	end
endmodule

// ---- rtl/brp_port.sv ----
`timescale 1ns/100ps
`include "brp_defs.svh"
module brp_port import brp_pkg::*; #(
	parameter int DATA_W = 20,
	parameter int DEPTH = `BRP_FIFO_DEPTH,
	parameter brp_cnt_t SETTLE_CYC = `BRP_SETTLE_CYC,
	parameter brp_cnt_t STROBE_CYC = `BRP_STROBE_CYC,
	parameter brp_cnt_t RELEASE_CYC = `BRP_RELEASE_CYC,
	parameter brp_cnt_t PERIOD_CYC = `BRP_PERIOD_CYC
)
(
	input wire logic mclk_in, // 40 MHz clock
	input wire logic rst_n_in, // Async reset, active low
	input wire logic [DATA_W-1:0] meas_data_in, // Measured BCD word
	input wire logic meas_valid_in, // Measurement offered
	output logic meas_ready_out, // FIFO has room
	input wire logic request_in, // Read request from reader
	input wire logic hold_in, // Freeze presented value
	output logic [DATA_W-1:0] bcd_out, // Open-collector pull-down drive
	output logic [DATA_W-1:0] bcd_oe_n_out, // Low while pulling line low
	output logic valid_out, // Strobe pull-down drive
	output logic valid_oe_n_out, // Low while strobe active
	output logic busy_out // Transfer in progress
);
	typedef struct packed
	{
		logic [1:0] rst_sync;
		brp_state_e st;
		brp_cnt_t cnt;
		brp_cnt_t per;
		logic req_prev;
		logic armed; // Held request may repeat
		logic [DATA_W-1:0] word;
		logic drive;
		logic strobe;
	} brp_port_s;
	brp_port_s q;
	brp_port_s d;
	logic rst_sync_n;
	logic [DATA_W-1:0] fifo_data;
	logic fifo_valid;
	logic fifo_pop;
	logic [1:0] rs1_q;

	// Reset release through two flops
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			rs1_q <= 2'h0;
		else
			rs1_q <= {rs1_q[0], 1'h1};
	end
	assign rst_sync_n = rs1_q[1];

	// Measurement buffer; back-pressure reaches the source
	brp_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(DEPTH)
	) u_fifo (
		.clk_in(mclk_in),
		.rst_n_in(rst_sync_n),
		.wr_data_in(meas_data_in),
		.wr_valid_in(meas_valid_in),
		.wr_ready_out(meas_ready_out),
		.rd_data_out(fifo_data),
		.rd_valid_out(fifo_valid),
		.rd_ready_in(fifo_pop)
	);

	// Pop one word per clock while not empty, keeping the newest; frozen while hold
	assign fifo_pop = fifo_valid && !hold_in;

	// Shared strobe start, used at the end of settling and for a repeat
	function automatic brp_port_s begin_strobe(input brp_port_s s, input logic frz,
		input logic [DATA_W-1:0] w);
		brp_port_s r;
		r = s;
		r.st = BRP_STROBE;
		r.drive = 1'b1;
		r.strobe = 1'b1;
		r.cnt = STROBE_CYC - 32'h1;
		// Period runs from this strobe start to the next one
		r.per = PERIOD_CYC - 32'h1;
		// Whole-word latch: a hold keeps the earlier word, never a partial one
		if (!frz)
			r.word = w;
		r.armed = 1'b1;
		return r;
	endfunction

	// Sequencer
	always_comb
	begin
		d = q;
		d.rst_sync = 2'h0;
		d.req_prev = request_in;
		// A request dropped after the strobe starts cancels any further repeat
		if (!request_in)
			d.armed = 1'b0;
		d.per = (q.per == 32'h0) ? 32'h0 : q.per - 32'h1;
		case (q.st)
			BRP_IDLE:
			begin
				d.drive = 1'b0;
				d.strobe = 1'b0;
				if (request_in && !q.req_prev)
				begin
					d.st = BRP_SETTLE;
					d.cnt = SETTLE_CYC - 32'h1;
				end
				// Held request: next word once the period has run out
				else if (request_in && q.armed && q.per == 32'h0)
					d = begin_strobe(d, hold_in, fifo_data);
			end
			BRP_SETTLE:
			begin
				d.cnt = q.cnt - 32'h1;
				if (q.cnt == 32'h0)
					d = begin_strobe(d, hold_in, fifo_data);
			end
			BRP_STROBE:
			begin
				d.cnt = q.cnt - 32'h1;
				if (q.cnt == 32'h0)
				begin
					d.st = BRP_TAIL;
					d.strobe = 1'b0;
					d.cnt = RELEASE_CYC - 32'h1;
				end
			end
			BRP_TAIL:
			begin
				d.cnt = q.cnt - 32'h1;
				// Data always released before any repeat may start
				if (q.cnt == 32'h0)
				begin
					d.drive = 1'b0;
					d.st = BRP_IDLE;
				end
			end
			default:
			begin
				d.st = BRP_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge mclk_in or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			q <= '0;
			q.st <= BRP_IDLE;
		end
		else
			q <= d;
	end

	// Open-collector: low level, enable low while pulling
	assign bcd_out = '0;
	assign bcd_oe_n_out = q.drive ? ~q.word : {DATA_W{1'b1}};
	assign valid_out = 1'b0;
	assign valid_oe_n_out = ~q.strobe;
	assign busy_out = (q.st != BRP_IDLE);
endmodule

// ---- verification/brp_port_asserts.sv ----
`timescale 1ns/100ps
module brp_port_asserts import brp_pkg::*; #(
	parameter int DATA_W = 20,
	parameter brp_cnt_t SETTLE_CYC = 30,
	parameter brp_cnt_t STROBE_CYC = 40,
	parameter brp_cnt_t RELEASE_CYC = 16
)
(
	input wire logic mclk_in, // Clock
	input wire logic rst_n_in, // Reset
	input wire logic request_in, // Read request
	input wire logic [DATA_W-1:0] bcd_out, // Data drive
	input wire logic [DATA_W-1:0] bcd_oe_n_out, // Data enables
	input wire logic valid_out, // Strobe drive
	input wire logic valid_oe_n_out, // Strobe enable
	input wire logic busy_out // Busy
);
	localparam int SET = SETTLE_CYC;
	localparam int STR = STROBE_CYC;
	localparam int REL = RELEASE_CYC;
	default clocking @(posedge mclk_in);
	endclocking
	default disable iff (!rst_n_in);
	a_bcd_low: assert property (bcd_out == '0)
		else $error("bcd drive high");
	a_valid_low: assert property (valid_out == 1'b0)
		else $error("strobe drive high");
	a_idle_released: assert property (!busy_out |-> &bcd_oe_n_out && valid_oe_n_out)
		else $error("lines held while idle");
	a_settle_time: assert property ($rose(request_in) && !busy_out |-> ##SET valid_oe_n_out ##1 !valid_oe_n_out)
		else $error("strobe not on time");
	a_strobe_len: assert property ($fell(valid_oe_n_out) |-> ##STR $rose(valid_oe_n_out))
		else $error("strobe length wrong");
	a_data_release: assert property ($rose(valid_oe_n_out) |-> ##REL &bcd_oe_n_out)
		else $error("data not released");
	a_word_steady: assert property (!valid_oe_n_out && $past(valid_oe_n_out) == 1'b0 |-> $stable(bcd_oe_n_out))
		else $error("data moved under strobe");
	a_strobe_busy: assert property (!valid_oe_n_out |-> busy_out)
		else $error("strobe without busy");
endmodule

// ---- verification/brp_reader.sv ----
`timescale 1ns/100ps
module brp_reader #(
	parameter int GAP = 20
)
(
	input wire logic clk_in, // Clock
	input wire logic go_in, // Ask for one word
	input wire logic keep_in, // Keep asking
	input wire logic [19:0] bcd_ln_in, // Data line levels
	input wire logic strobe_ln_in, // Strobe line level
	output logic request_out = 1'b0, // Read request
	output logic [19:0] word_out = 20'h00000, // Captured word
	output logic got_out = 1'b0 // Capture pulse
);
	int gap_q = 0;
	logic st_q = 1'b1;
	// Request after the gap; capture once, on the first clock the strobe line is seen low
	always_ff @(posedge clk_in)
	begin
		st_q <= strobe_ln_in;
		gap_q <= strobe_ln_in ? gap_q + 1 : 0;
		request_out <= (go_in | keep_in) & (gap_q >= GAP | request_out);
		got_out <= st_q & !strobe_ln_in;
		if (st_q && !strobe_ln_in)
			word_out <= ~bcd_ln_in;
	end
endmodule

// ---- verification/brp_port_tb.sv ----
`timescale 1ns/100ps
module brp_port_tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [19:0] md = 20'h00000;
	logic mv = 1'b0;
	logic hold = 1'b0;
	logic go = 1'b0;
	logic keep = 1'b0;
	logic req, mr, vo, vn, busy, got;
	logic [19:0] bo, bn, word;
	int mismatches = 0;
	int check_count = 0;
	time t0;
	logic [39:0] rows [4] = '{40'h1234512345, 40'h9999999999, 40'h0000100001, 40'h5050550505};
	// Clock
	initial
	begin
		forever #12.5 clk = ~clk;
	end
	brp_port #(.SETTLE_CYC(30), .STROBE_CYC(40), .RELEASE_CYC(16), .PERIOD_CYC(64)) DUT (
		.mclk_in(clk), .rst_n_in(rst_n), .meas_data_in(md), .meas_valid_in(mv),
		.meas_ready_out(mr), .request_in(req), .hold_in(hold), .bcd_out(bo),
		.bcd_oe_n_out(bn), .valid_out(vo), .valid_oe_n_out(vn), .busy_out(busy));
	brp_reader rdr (.clk_in(clk), .go_in(go), .keep_in(keep), .bcd_ln_in(bo | bn),
		.strobe_ln_in(vo | vn), .request_out(req), .word_out(word), .got_out(got));
	task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] s);
		check_count++;
		if (s !== e)
		begin
			mismatches++;
			$display("ERROR %s exp %h got %h", nm, e, s);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic wt(ref logic s, input logic v);
		int n;
		n = 0;
		while (s !== v && n < 400)
		begin
			@(posedge clk);
			n++;
		end
		if (n == 400)
		begin
			mismatches++;
			end_of_test();
		end
	endtask
	// Offer one word; ready checked settled, before the taking edge
	task automatic put(input logic [19:0] w, input logic e);
		md <= w;
		mv <= 1'b1;
		#1;
		chk("ready", {19'h0, e}, {19'h0, mr});
		@(posedge clk);
		mv <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [19:0] e);
		go <= 1'b1;
		wt(got, 1'b1);
		go <= 1'b0;
		chk("word", e, word);
		wt(busy, 1'b0);
	endtask
	initial
	begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (5) @(posedge clk);
		for (int i = 0; i < 4; i++)
		begin
			put(rows[i][39:20], 1'b1);
			rd(rows[i][19:0]);
			$display("row %0d done", i);
		end
		hold <= 1'b1;
		for (int i = 0; i < 17; i++)
			put(20'h10000 + 20'(i), i < 16);
		rd(20'h50505);
		$display("hold test done");
		hold <= 1'b0;
		keep <= 1'b1;
		wt(got, 1'b1);
		chk("repeat1", 20'h1000F, word);
		t0 = $time;
		@(posedge clk);
		wt(got, 1'b1);
		chk("repeat2", 20'h1000F, word);
		chk("period", 20'h00040, 20'(($time - t0) / 25));
		keep <= 1'b0;
		wt(busy, 1'b0);
		$display("repeat test done");
		// Mid-run reset: data lines released, busy low, then a fresh read works
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		chk("reset lines", 20'hFFFFF, bn);
		chk("reset busy", 20'h00000, {19'h0, busy});
		rst_n <= 1'b1;
		repeat (5) @(posedge clk);
		put(20'h24680, 1'b1);
		rd(20'h24680);
		$display("reset test done");
		end_of_test();
	end
endmodule
bind brp_port brp_port_asserts #(.DATA_W(DATA_W), .SETTLE_CYC(SETTLE_CYC),
	.STROBE_CYC(STROBE_CYC), .RELEASE_CYC(RELEASE_CYC)) chk_i (.mclk_in(mclk_in),
	.rst_n_in(rst_n_in), .request_in(request_in), .bcd_out(bcd_out),
	.bcd_oe_n_out(bcd_oe_n_out), .valid_out(valid_out), .valid_oe_n_out(valid_oe_n_out),
	.busy_out(busy_out));
